// ==== common/fdcc_pkg.sv ====
// Types for the floppy config bank
package fdcc_pkg;
    typedef enum logic [1:0] {
        FDCC_ROUTE_PP_MODE = 2'b00,
        FDCC_ROUTE_DRV1_PP = 2'b01,
        FDCC_ROUTE_BOTH_PP = 2'b10,
        FDCC_ROUTE_RSVD = 2'b11
    } fdcc_route_type;
endpackage

// ==== common/fdcc_regs.svh ====
// Register offsets, reset values and field positions for the floppy config bank
`ifndef FDCC_REGS_SVH
`define FDCC_REGS_SVH
`define FDCC_IDX_DRIVE_TYPE 8'h1F
`define FDCC_IDX_BASE 8'h20
`define FDCC_IDX_ROUTING 8'h21
`define FDCC_RST_DRIVE_TYPE 8'h00
`define FDCC_RST_BASE 8'h3C
`define FDCC_RST_ROUTING 8'h00
`define FDCC_BASE_WR_MASK 8'hFC
`define FDCC_ROUTING_WR_MASK 8'h03
`define FDCC_RST_INDEX 8'h00
`define FDCC_READ_NONE 8'h00
`define FDCC_ADDR_HI 15:10
`define FDCC_ADDR_MID 9:4
`define FDCC_ADDR_B3 3
`define FDCC_ADDR_LO 2:0
`define FDCC_BASE_ADR 7:2
`define FDCC_BASE_TOP 7:6
`define FDCC_ROUTE_BITS 1:0
`endif

// ==== core/fdcc_config_bank.sv ====
// Floppy controller configuration registers, decoder and pin mapping
// How it works
// - The drive type register is reached only in the configuration state with index 1FH loaded.
// - Drive n keeps type bit one in bit 2n and type bit zero in bit 2n+1.
// - The drive type selects which controller outputs appear on the two density pins.
// - The drive type register is read/write and resets to zero.
// - The base address register is reached only in the configuration state with index 20H.
// - Base register bits 7..2 give host address bits 9..4 for the decoder.
// - Zero in both address bits 9 and 8 disables the controller decode.
// - The two low base register bits read zero and software writes them as zero.
// - An access is claimed only if address bits 15..10 and bit 3 are zero.
// - The base address register resets to 3CH.
// - The routing register is reached only in the configuration state with index 21H.
// - Routing field zero hands control to the parallel port mode bits and ignores the pin.
// - The routing register is read/write and resets to zero.
// - Field 01 with the pin low puts drive 0 on floppy pins and drive 1 on the parallel port.
// - Field 10 with the pin low puts both drives on the parallel port; 11 is reserved.
`timescale 1ns/100ps
`include "fdcc_regs.svh"
module fdcc_config_bank
    import fdcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration access
    input wire logic config_state,
    input wire logic index_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    // Host I/O decode
    input wire logic [15:0] io_addr,
    input wire logic io_cycle,
    output logic fdc_select,
    output logic [2:0] fdc_reg_sel,
    // Controller drive outputs
    input wire logic [1:0] drive_select,
    input wire logic density_select_out,
    input wire logic rate_code_low,
    input wire logic rate_code_high,
    output logic density_pin_zero,
    output logic density_pin_one,
    // Routing
    input wire logic floppy_on_printer_port,
    input wire logic pp_mode_fdc_drv0,
    input wire logic pp_mode_fdc_drv1,
    output logic drv0_on_pp,
    output logic drv1_on_pp
);
    logic [7:0] index_r;
    logic [7:0] index_nxt;
    logic [7:0] drive_type_map_r;
    logic [7:0] drive_type_map_nxt;
    logic [7:0] floppy_base_address_r;
    logic [7:0] floppy_base_address_nxt;
    logic [7:0] floppy_port_routing_r;
    logic [7:0] floppy_port_routing_nxt;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic fdc_select_r;
    logic fdc_select_nxt;
    logic [2:0] fdc_reg_sel_r;
    logic [2:0] fdc_reg_sel_nxt;
    logic den0_r;
    logic den0_nxt;
    logic den1_r;
    logic den1_nxt;
    logic drv0_pp_r;
    logic drv0_pp_nxt;
    logic drv1_pp_r;
    logic drv1_pp_nxt;
    logic [1:0] type_bits [4];
    logic sel_t0;
    logic sel_t1;
    logic map0;
    logic map1;
    logic cfg_index_wr;
    logic cfg_data_wr;
    logic cfg_data_rd;
    logic addr_upper_clear;
    logic addr_block_hit;
    logic base_enabled;
    fdcc_route_type route;

    // Accesses outside the configuration state are dropped
    assign cfg_index_wr = config_state && index_wr;
    assign cfg_data_wr = config_state && data_wr;
    assign cfg_data_rd = config_state && data_rd;

    // Per-drive type fields
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_type
            assign type_bits[g] = {drive_type_map_r[2*g+1], drive_type_map_r[2*g]};
        end
    endgenerate

    assign sel_t0 = type_bits[drive_select][1];
    assign sel_t1 = type_bits[drive_select][0];

    fdcc_density_map u_map (
        .type_bit_zero(sel_t0),
        .type_bit_one(sel_t1),
        .density_select_out(density_select_out),
        .rate_code_low(rate_code_low),
        .rate_code_high(rate_code_high),
        .density_pin_zero(map0),
        .density_pin_one(map1)
    );

    assign route = fdcc_route_type'(floppy_port_routing_r[`FDCC_ROUTE_BITS]);

    // Index register
    always_comb begin
        index_nxt = index_r;
        if (cfg_index_wr) begin
            index_nxt = wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            index_r <= `FDCC_RST_INDEX;
        end else begin
            index_r <= index_nxt;
        end
    end

    // Data write goes to the index held before this edge
    always_comb begin
        drive_type_map_nxt = drive_type_map_r;
        floppy_base_address_nxt = floppy_base_address_r;
        floppy_port_routing_nxt = floppy_port_routing_r;
        if (cfg_data_wr) begin
            case (index_r)
                `FDCC_IDX_DRIVE_TYPE: begin
                    drive_type_map_nxt = wr_data;
                end
                `FDCC_IDX_BASE: begin
                    floppy_base_address_nxt = wr_data & `FDCC_BASE_WR_MASK;
                end
                `FDCC_IDX_ROUTING: begin
                    floppy_port_routing_nxt = wr_data & `FDCC_ROUTING_WR_MASK;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            drive_type_map_r <= `FDCC_RST_DRIVE_TYPE;
            floppy_base_address_r <= `FDCC_RST_BASE;
            floppy_port_routing_r <= `FDCC_RST_ROUTING;
        end else begin
            drive_type_map_r <= drive_type_map_nxt;
            floppy_base_address_r <= floppy_base_address_nxt;
            floppy_port_routing_r <= floppy_port_routing_nxt;
        end
    end

    // Read data holds until the next read
    always_comb begin
        rd_data_nxt = rd_data_r;
        if (cfg_data_rd) begin
            case (index_r)
                `FDCC_IDX_DRIVE_TYPE: rd_data_nxt = drive_type_map_r;
                `FDCC_IDX_BASE: rd_data_nxt = floppy_base_address_r;
                `FDCC_IDX_ROUTING: rd_data_nxt = floppy_port_routing_r;
                default: rd_data_nxt = `FDCC_READ_NONE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_r <= `FDCC_READ_NONE;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // Host address decoder
    always_comb begin
        addr_upper_clear = io_addr[`FDCC_ADDR_HI] == 6'h00;
        addr_block_hit = io_addr[`FDCC_ADDR_MID] == floppy_base_address_r[`FDCC_BASE_ADR];
        base_enabled = floppy_base_address_r[`FDCC_BASE_TOP] != 2'h0;
        fdc_select_nxt = io_cycle && addr_upper_clear && !io_addr[`FDCC_ADDR_B3]
            && addr_block_hit && base_enabled;
        fdc_reg_sel_nxt = io_addr[`FDCC_ADDR_LO];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fdc_select_r <= 1'b0;
            fdc_reg_sel_r <= 3'h0;
        end else begin
            fdc_select_r <= fdc_select_nxt;
            fdc_reg_sel_r <= fdc_reg_sel_nxt;
        end
    end

    // Density pins follow the selected drive every cycle
    always_comb begin
        den0_nxt = map0;
        den1_nxt = map1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            den0_r <= 1'b0;
            den1_r <= 1'b0;
        end else begin
            den0_r <= den0_nxt;
            den1_r <= den1_nxt;
        end
    end

    // Drive routing onto the parallel port pins
    always_comb begin
        case (route)
            FDCC_ROUTE_PP_MODE: begin
                drv0_pp_nxt = pp_mode_fdc_drv0;
                drv1_pp_nxt = pp_mode_fdc_drv1;
            end
            FDCC_ROUTE_DRV1_PP: begin
                drv0_pp_nxt = 1'b0;
                drv1_pp_nxt = !floppy_on_printer_port;
            end
            FDCC_ROUTE_BOTH_PP: begin
                drv0_pp_nxt = !floppy_on_printer_port;
                drv1_pp_nxt = !floppy_on_printer_port;
            end
            default: begin
                drv0_pp_nxt = 1'b0;
                drv1_pp_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            drv0_pp_r <= 1'b0;
            drv1_pp_r <= 1'b0;
        end else begin
            drv0_pp_r <= drv0_pp_nxt;
            drv1_pp_r <= drv1_pp_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign fdc_select = fdc_select_r;
    assign fdc_reg_sel = fdc_reg_sel_r;
    assign density_pin_zero = den0_r;
    assign density_pin_one = den1_r;
    assign drv0_on_pp = drv0_pp_r;
    assign drv1_on_pp = drv1_pp_r;
endmodule // fdcc_config_bank

// ==== core/fdcc_density_map.sv ====
// Drive type to density pin mapping
`timescale 1ns/100ps
module fdcc_density_map
    import fdcc_pkg::*;
(
    // Drive type of the selected drive
    input wire logic type_bit_zero,
    input wire logic type_bit_one,
    // Controller outputs
    input wire logic density_select_out,
    input wire logic rate_code_low,
    input wire logic rate_code_high,
    // Mapped pins
    output logic density_pin_zero,
    output logic density_pin_one
);
    always_comb begin
        case ({type_bit_zero, type_bit_one})
            2'b00: begin
                density_pin_zero = density_select_out;
                density_pin_one = rate_code_low;
            end
            2'b01: begin
                density_pin_zero = rate_code_high;
                density_pin_one = rate_code_low;
            end
            2'b10: begin
                density_pin_zero = ~density_select_out;
                density_pin_one = rate_code_low;
            end
            default: begin
                density_pin_zero = rate_code_low;
                density_pin_one = rate_code_high;
            end
        endcase
    end
endmodule // fdcc_density_map

// ==== testbench/fdcc_config_bank_checker.sv ====
// Assertions on the floppy config bank ports
`timescale 1ns/100ps
module fdcc_config_bank_checker
    import fdcc_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic rst,
    // Configuration access
    input logic config_state,
    input logic index_wr,
    input logic data_wr,
    input logic data_rd,
    input logic [7:0] wr_data,
    input logic [7:0] rd_data,
    // Host decode
    input logic [15:0] io_addr,
    input logic io_cycle,
    input logic fdc_select,
    input logic [2:0] fdc_reg_sel,
    // Drive side
    input logic [1:0] drive_select,
    input logic density_select_out,
    input logic rate_code_low,
    input logic rate_code_high,
    input logic density_pin_zero,
    input logic density_pin_one,
    // Routing
    input logic floppy_on_printer_port,
    input logic pp_mode_fdc_drv0,
    input logic pp_mode_fdc_drv1,
    input logic drv0_on_pp,
    input logic drv1_on_pp
);
    logic [7:0] idx_r, idx_nxt, base_r, base_nxt;
    logic [1:0] rt_r, rt_nxt;
    logic rd;
    // Shadow of the index, base and routing registers
    always_comb begin
        rd = config_state && data_rd;
        idx_nxt = config_state && index_wr ? wr_data : idx_r;
        base_nxt = config_state && data_wr && idx_r == 8'h20 ? wr_data & 8'hFC : base_r;
        rt_nxt = config_state && data_wr && idx_r == 8'h21 ? wr_data[1:0] : rt_r;
    end
    always_ff @(posedge clk) begin
        idx_r <= rst ? 8'h00 : idx_nxt;
        base_r <= rst ? 8'h3C : base_nxt;
        rt_r <= rst ? 2'b00 : rt_nxt;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_claim; fdc_select |-> $past(io_addr[15:10] == 6'h00 && !io_addr[3]); endproperty
    a_claim: assert property (p_claim) else $error("stray claim");
    property p_decode; io_cycle && io_addr[15:10] == 6'h00 && !io_addr[3]
        && io_addr[9:4] == base_r[7:2] && base_r[7:6] != 2'b00
        |=> fdc_select && fdc_reg_sel == $past(io_addr[2:0]); endproperty
    a_decode: assert property (p_decode) else $error("missed claim");
    property p_off; base_r[7:6] == 2'b00 |=> !fdc_select; endproperty
    a_off: assert property (p_off) else $error("claim while off");
    property p_hold; !rd |=> $stable(rd_data); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap; rd && idx_r[7:1] != 7'h10 && idx_r != 8'h1F |=> rd_data == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_pp; rt_r == 2'b00 |=> drv0_on_pp == $past(pp_mode_fdc_drv0)
        && drv1_on_pp == $past(pp_mode_fdc_drv1); endproperty
    a_pp: assert property (p_pp) else $error("mode routing");
    property p_one; rt_r == 2'b01
        |=> !drv0_on_pp && drv1_on_pp == !$past(floppy_on_printer_port); endproperty
    a_one: assert property (p_one) else $error("drive one routing");
    property p_two; rt_r == 2'b10 |=> drv0_on_pp == !$past(floppy_on_printer_port)
        && drv1_on_pp == drv0_on_pp; endproperty
    a_two: assert property (p_two) else $error("both drive routing");
    c_claim: cover property (fdc_select);
    c_one: cover property (rt_r == 2'b01 && !floppy_on_printer_port);
    c_read: cover property (rd && idx_r == 8'h1F);
endmodule // fdcc_config_bank_checker
bind fdcc_config_bank fdcc_config_bank_checker u_checker (.*);

// ==== testbench/fdcc_drive_model.sv ====
// Drive side model stepping through all controller output codes
`timescale 1ns/100ps
module fdcc_drive_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller outputs toward the drives
    output logic [1:0] drive_select,
    output logic density_select_out,
    output logic rate_code_low,
    output logic rate_code_high
);
    logic [4:0] step_r, step_nxt;
    always_comb step_nxt = rst ? 5'h00 : step_r + 5'h01;
    always_ff @(posedge clk) step_r <= step_nxt;
    assign {drive_select, density_select_out, rate_code_high, rate_code_low} = step_r;
endmodule // fdcc_drive_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the floppy config bank
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0] DT_MAP = 8'hE4;
    logic clk, rst, config_state, index_wr, data_wr, data_rd, io_cycle, fdc_select;
    logic floppy_on_printer_port, pp_mode_fdc_drv0, pp_mode_fdc_drv1, drv0_on_pp, drv1_on_pp;
    logic density_select_out, rate_code_low, rate_code_high, density_pin_zero, density_pin_one;
    logic [7:0] wr_data, rd_data;
    logic [15:0] io_addr;
    logic [2:0] fdc_reg_sel;
    logic [1:0] drive_select, exp_den, exp_pp;
    int err_count = 0, check_count = 0, cyc = 0;
    fdcc_config_bank dut (.*);
    fdcc_drive_model u_drives (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Expected density pins for the selected drive
    always @(posedge clk) begin
        cyc <= cyc + 1;
        case ({DT_MAP[{drive_select, 1'b1}], DT_MAP[{drive_select, 1'b0}]})
            2'b00: exp_den <= {density_select_out, rate_code_low};
            2'b01: exp_den <= {rate_code_high, rate_code_low};
            2'b10: exp_den <= {!density_select_out, rate_code_low};
            default: exp_den <= {rate_code_low, rate_code_high};
        endcase
        if (cyc == 2000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic [7:0] i, input logic [7:0] d, input logic r);
        @(posedge clk);
        index_wr <= 1'b1;
        wr_data <= i;
        @(posedge clk);
        index_wr <= 1'b0;
        data_wr <= !r;
        data_rd <= r;
        wr_data <= d;
        @(posedge clk);
        data_wr <= 1'b0;
        data_rd <= 1'b0;
    endtask
    task automatic get(input logic [7:0] i, input logic [7:0] e);
        acc(i, 8'h00, 1'b1);
        @(negedge clk);
        chk("rd_data", e, rd_data);
    endtask
    task automatic io(input logic [15:0] a, input logic e);
        @(posedge clk);
        io_addr <= a;
        io_cycle <= 1'b1;
        @(posedge clk);
        io_cycle <= 1'b0;
        @(negedge clk);
        chk("fdc_select", {7'h00, e}, {7'h00, fdc_select});
        if (e) chk("fdc_reg_sel", {5'h00, a[2:0]}, {5'h00, fdc_reg_sel});
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        {rst, config_state, floppy_on_printer_port, pp_mode_fdc_drv0} = 4'hF;
        {index_wr, data_wr, data_rd, io_cycle, pp_mode_fdc_drv1} = 5'h00;
        wr_data = 8'h00;
        io_addr = 16'h0000;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        get(8'h1F, 8'h00);
        get(8'h21, 8'h00);
        get(8'h22, 8'h00);
        get(8'h20, 8'h3C);
        io(16'h00F2, 1'b0);
        @(posedge clk) config_state <= 1'b0;
        acc(8'h20, 8'h00, 1'b0);
        @(posedge clk) config_state <= 1'b1;
        get(8'h20, 8'h3C);
        acc(8'h20, 8'h4C, 1'b0);
        get(8'h20, 8'h4C);
        io(16'h0135, 1'b1);
        io(16'h013D, 1'b0);
        io(16'h0535, 1'b0);
        io(16'h0145, 1'b0);
        acc(8'h20, 8'h30, 1'b0);
        io(16'h00C0, 1'b0);
        acc(8'h1F, DT_MAP, 1'b0);
        get(8'h1F, DT_MAP);
        repeat (32) begin
            @(negedge clk);
            chk("density", {6'h00, exp_den}, {6'h00, density_pin_zero, density_pin_one});
        end
        acc(8'h21, 8'hFF, 1'b0);
        get(8'h21, 8'h03);
        for (int k = 0; k < 8; k++) begin
            acc(8'h21, {6'h00, k[1:0]}, 1'b0);
            floppy_on_printer_port <= k[2];
            pp_mode_fdc_drv0 <= k[2];
            pp_mode_fdc_drv1 <= !k[2];
            repeat (2) @(posedge clk);
            @(negedge clk);
            case (k[1:0])
                2'b00: exp_pp = {k[2], !k[2]};
                2'b01: exp_pp = {1'b0, !k[2]};
                2'b10: exp_pp = {2{!k[2]}};
                default: exp_pp = 2'b00;
            endcase
            chk("routing", {6'h00, exp_pp}, {6'h00, drv0_on_pp, drv1_on_pp});
        end
        finish_test();
    end
endmodule // tb_top
